/* dv/qdec_properties.sv */
`timescale 1ns/1ps
// timing relations seen at the decoder pins
module qdec_properties (
  input wire logic                       I_CORE_CLK,
  input wire logic                       I_RST_N,
  input wire logic                       I_CE,
  input wire logic                       I_IDX_CLR_EN,
  input wire logic [qdec_pkg::CNT_W-1:0] I_VEL_CMP,
  input wire logic [qdec_pkg::CNT_W-1:0] I_POS_CMP0,
  input wire logic [qdec_pkg::CNT_W-1:0] I_IDX_CMP,
  input wire logic [qdec_pkg::INT_W-1:0] I_INT_EN,
  input wire logic [qdec_pkg::INT_W-1:0] I_INT_CLR,
  input wire logic [qdec_pkg::CNT_W-1:0] O_POS,
  input wire logic [qdec_pkg::CNT_W-1:0] O_VEL,
  input wire logic [qdec_pkg::CNT_W-1:0] O_IDX_CNT,
  input wire logic                       O_DIR,
  input wire logic [qdec_pkg::INT_W-1:0] O_INT_STAT,
  input wire logic                       O_INT
);
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_N);
  // request line is registered from the same next flags as the status
  property p_int; I_CE && I_RST_N |=> O_INT == |(O_INT_STAT & $past(I_INT_EN));
  endproperty
  property p_step; $changed(O_POS) |-> O_POS == $past(O_POS) + qdec_pkg::ONE
    || O_POS == $past(O_POS) - qdec_pkg::ONE || O_POS == qdec_pkg::POS_RST; endproperty
  property p_up; O_POS == $past(O_POS) + qdec_pkg::ONE && O_POS != qdec_pkg::POS_RST
    |-> O_DIR; endproperty
  property p_idx; $changed(O_IDX_CNT) |-> O_IDX_CNT == $past(O_IDX_CNT) + qdec_pkg::ONE
    && O_INT_STAT[qdec_pkg::INT_IDX]; endproperty
  property p_iclr; $changed(O_IDX_CNT) && $past(I_IDX_CLR_EN)
    |-> O_POS == qdec_pkg::POS_RST; endproperty
  property p_vcap; $changed(O_VEL) |-> O_INT_STAT[qdec_pkg::INT_TIM]; endproperty
  property p_vlt; $rose(O_INT_STAT[qdec_pkg::INT_VELLT]) |-> O_VEL < $past(I_VEL_CMP);
  endproperty
  property p_cmp; $rose(O_INT_STAT[qdec_pkg::INT_POS0]) |-> O_POS == $past(I_POS_CMP0);
  endproperty
  property p_rev; $rose(O_INT_STAT[qdec_pkg::INT_REV]) |-> O_IDX_CNT == $past(I_IDX_CMP);
  endproperty
  // a flag may only drop where its clear was asserted
  property p_keep;
    ($past(O_INT_STAT) & ~O_INT_STAT & ~$past(I_INT_CLR)) == qdec_pkg::STAT_RST;
  endproperty

  a_int: assert property (p_int) else $error("request line wrong");
  a_step: assert property (p_step) else $error("position jumped");
  a_up: assert property (p_up) else $error("direction wrong on up count");
  a_idx: assert property (p_idx) else $error("revolution count wrong");
  a_iclr: assert property (p_iclr) else $error("index did not clear position");
  a_vcap: assert property (p_vcap) else $error("capture without window flag");
  a_vlt: assert property (p_vlt) else $error("low speed flag wrong");
  a_cmp: assert property (p_cmp) else $error("position match flag wrong");
  a_rev: assert property (p_rev) else $error("index match flag wrong");
  a_keep: assert property (p_keep) else $error("flag dropped uncleared");

  c_rev: cover property ($rose(O_INT_STAT[qdec_pkg::INT_REV]));
  c_comb: cover property ($rose(O_INT_STAT[qdec_pkg::INT_COMB]));
  c_vlt: cover property ($rose(O_INT_STAT[qdec_pkg::INT_VELLT]));
endmodule

bind quadrature_decoder qdec_properties chk_i (.I_CORE_CLK, .I_RST_N, .I_CE, .I_IDX_CLR_EN,
  .I_VEL_CMP, .I_POS_CMP0, .I_IDX_CMP, .I_INT_EN, .I_INT_CLR, .O_POS, .O_VEL, .O_IDX_CNT,
  .O_DIR, .O_INT_STAT, .O_INT);

/* dv/qenc_model.sv */
`timescale 1ns/1ps
// incremental encoder with index; lines move only when told to
module qenc_model (
  input  wire logic i_clk,
  output logic      o_pha,
  output logic      o_phb,
  output logic      o_idx
);
  int gap = 4; // cycles a level stands; must outlast the filter delay

  // encoder at rest with all lines low
  initial begin
    o_pha = 1'b0;
    o_phb = 1'b0;
    o_idx = 1'b0;
  end

  // change the lines just after an edge, then hold them for gap cycles
  task automatic put(input logic a, input logic b, input logic i);
    @(posedge i_clk);
    o_pha <= a;
    o_phb <= b;
    o_idx <= i;
    repeat (gap - 1) @(posedge i_clk);
  endtask

  // one quadrature step; going up, phase A leads phase B
  task automatic step(input logic up);
    if (up) put(~o_phb, o_pha, 1'b0);
    else put(o_phb, ~o_pha, 1'b0);
  endtask
endmodule

/* dv/tb_top.sv */
`timescale 1ns/1ps
// encoder model into the decoder; counts and flags checked at the pins
module tb_top;
  logic                        clk;   // core clock
  logic                        rst_n; // synchronous reset
  logic                        pha;   // encoder lines
  logic                        phb;
  logic                        idx;
  logic [qdec_pkg::FILT_W-1:0] dly;   // filter delay
  logic                        m4x;   // resolution select
  logic                        cdir;  // clock and direction input
  logic                        iclr;  // index clears position
  logic [qdec_pkg::CNT_W-1:0]  c0;    // position compares
  logic [qdec_pkg::CNT_W-1:0]  c1;
  logic [qdec_pkg::CNT_W-1:0]  c2;
  logic [qdec_pkg::CNT_W-1:0]  icmp;  // revolution compare
  logic [qdec_pkg::INT_W-1:0]  en;    // request enables
  logic [qdec_pkg::INT_W-1:0]  clr_v; // flag clears
  logic                        ce;    // clock enable
  logic                        dinv;  // direction inversion
  logic                        pclr;  // position clear
  logic [qdec_pkg::CNT_W-1:0]  pos;   // observed outputs
  logic [qdec_pkg::CNT_W-1:0]  vel;
  logic [qdec_pkg::CNT_W-1:0]  icnt;
  logic                        dir;
  logic [qdec_pkg::INT_W-1:0]  stat;
  logic                        irq;
  int                          err_total = 0; // mismatches
  int                          checked = 0;   // comparisons

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  qenc_model enc (.i_clk(clk), .o_pha(pha), .o_phb(phb), .o_idx(idx));

  // window of 100 cycles, low speed threshold of 5 steps
  quadrature_decoder dut (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_CE(ce), .I_PHA(pha),
    .I_PHB(phb), .I_IDX(idx), .I_FILT_DLY(dly), .I_MODE_4X(m4x), .I_CLKDIR_MODE(cdir),
    .I_DIR_INV(dinv), .I_IDX_CLR_EN(iclr), .I_POS_CLR(pclr), .I_VEL_PERIOD(32'h0000_0063),
    .I_VEL_CMP(32'h0000_0005), .I_POS_CMP0(c0), .I_POS_CMP1(c1), .I_POS_CMP2(c2),
    .I_IDX_CMP(icmp), .I_INT_EN(en), .I_INT_CLR(clr_v), .O_POS(pos), .O_VEL(vel),
    .O_IDX_CNT(icnt), .O_DIR(dir), .O_INT_STAT(stat), .O_INT(irq));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // longer than the slowest filter plus decode latency used here
  task automatic settle();
    repeat (12) @(posedge clk);
    #1;
  endtask

  task automatic clr(input logic [8:0] m);
    @(posedge clk);
    clr_v <= m;
    @(posedge clk);
    clr_v <= 9'h000;
  endtask

  // clear window and low speed flags, then wait for the next window end
  task automatic wwin();
    int n;
    clr(9'h006);
    #1;
    n = 0;
    while (stat[qdec_pkg::INT_TIM] !== 1'b1 && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 300) begin
      err_total++;
      summarize();
    end
  endtask

  initial begin
    rst_n = 1'b0;
    dly = 16'h0000;
    m4x = 1'b1;
    cdir = 1'b0;
    iclr = 1'b0;
    c0 = 32'h0000_1000;
    c1 = 32'h0000_1001;
    c2 = 32'h0000_1002;
    icmp = 32'h0000_0002;
    en = 9'h000;
    clr_v = 9'h000;
    ce = 1'b1;
    dinv = 1'b0;
    pclr = 1'b0;
    repeat (19) @(posedge clk);
    #1;
    chk("stat", stat, 32'h0);
    chk("pos", pos, 32'h0);
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) enc.step(1'b1);
    settle();
    chk("pos", pos, 32'h8);
    chk("dir", dir, 32'h1);
    repeat (3) enc.step(1'b0);
    settle();
    chk("pos", pos, 32'h5);
    chk("dir", dir, 32'h0);
    // half resolution: only phase A edges count
    @(posedge clk);
    m4x <= 1'b0;
    repeat (4) enc.step(1'b1);
    settle();
    chk("pos", pos, 32'h7);
    @(posedge clk);
    cdir <= 1'b1;
    repeat (2) begin
      enc.put(1'b0, 1'b1, 1'b0);
      enc.put(1'b1, 1'b1, 1'b0);
    end
    enc.put(1'b0, 1'b0, 1'b0);
    enc.put(1'b1, 1'b0, 1'b0);
    enc.put(1'b0, 1'b0, 1'b0);
    settle();
    chk("pos", pos, 32'h8);
    @(posedge clk);
    cdir <= 1'b0;
    m4x <= 1'b1;
    dly <= 16'h0005;
    enc.gap = 2;
    enc.put(1'b1, 1'b0, 1'b0);
    enc.put(1'b0, 1'b0, 1'b0);
    enc.gap = 10;
    settle();
    chk("pos", pos, 32'h8);
    enc.put(1'b1, 1'b0, 1'b0);
    settle();
    chk("pos", pos, 32'h9);
    enc.put(1'b0, 1'b0, 1'b0);
    @(posedge clk);
    dly <= 16'h0000;
    iclr <= 1'b1;
    enc.gap = 4;
    clr(9'h1FF);
    enc.put(1'b0, 1'b0, 1'b1);
    enc.put(1'b0, 1'b0, 1'b0);
    settle();
    chk("icnt", icnt, 32'h1);
    chk("pos", pos, 32'h0);
    enc.put(1'b0, 1'b0, 1'b1);
    enc.put(1'b0, 1'b0, 1'b0);
    settle();
    chk("rev", stat[7], 32'h1);
    @(posedge clk);
    c0 <= 32'h0000_0001;
    c1 <= 32'h0000_0002;
    c2 <= 32'h0000_0003;
    repeat (3) enc.step(1'b1);
    settle();
    chk("cmp", stat[6:4], 32'h7);
    chk("comb", stat[8], 32'h1);
    chk("irq", irq, 32'h0);
    @(posedge clk);
    en <= 9'h010;
    settle();
    chk("irq", irq, 32'h1);
    clr(9'h010);
    settle();
    chk("irq", irq, 32'h0);
    // position clear, then an inverted up step counts down
    @(posedge clk);
    pclr <= 1'b1;
    dinv <= 1'b1;
    @(posedge clk);
    pclr <= 1'b0;
    enc.step(1'b1);
    settle();
    chk("pos", pos, 32'hFFFF_FFFF);
    // ten steps inside one window, then an idle window
    wwin();
    repeat (10) enc.step(1'b1);
    wwin();
    chk("vel", vel, 32'hA);
    chk("slow", stat[2], 32'h0);
    wwin();
    chk("vel", vel, 32'h0);
    chk("slow", stat[2], 32'h1);
    summarize();
  end

  // whole run is near 620 cycles; about thirty-two times that means a hang
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    summarize();
  end
endmodule

/* inc/filt_if.sv */
`timescale 1ns/1ps
// one encoder line before and after its glitch filter
interface filt_if;
  logic raw_lvl;   // level as it arrives
  logic clean_lvl; // level after the filter has accepted it
  modport filt (input raw_lvl, output clean_lvl);
  modport user (output raw_lvl, input clean_lvl);
endinterface

/* inc/qdec_pkg.sv */
// Notes on behaviour
// [RULE1] direction from which phase leads
// [RULE2] index pulse optionally clears position
// [RULE3] position counts up or down
// [RULE4] selectable 2x or 4x resolution
// [RULE5] velocity counted over internal timer period
// [RULE6] interrupt when captured velocity below threshold
// [RULE7] position and velocity are 32 bits
// [RULE8] three position compares with interrupts
// [RULE9] index counter counts revolutions
// [RULE10] index compare match raises interrupt
// [RULE11] combined index plus position match interrupt
// [RULE12] programmable digital filter on each input
// [RULE13] clock and direction input mode
// [RULE14] 4x all edges, 2x phase A only
// [RULE15] filter passes level stable for N cycles
// [RULE16] sticky flags, per-source enable, explicit clear
package qdec_pkg;
  // data widths
  localparam int unsigned CNT_W  = 32; // position, velocity, index count
  localparam int unsigned FILT_W = 16; // filter delay count width
  localparam int unsigned INT_W  = 9;  // number of interrupt sources

  // interrupt status bit positions
  localparam int unsigned INT_IDX   = 0; // index pulse seen
  localparam int unsigned INT_TIM   = 1; // velocity period ended
  localparam int unsigned INT_VELLT = 2; // captured velocity below threshold
  localparam int unsigned INT_DIR   = 3; // direction changed
  localparam int unsigned INT_POS0  = 4; // position compare 0 hit
  localparam int unsigned INT_POS1  = 5; // position compare 1 hit
  localparam int unsigned INT_POS2  = 6; // position compare 2 hit
  localparam int unsigned INT_REV   = 7; // index compare hit
  localparam int unsigned INT_COMB  = 8; // position 0 hit while index count equals its compare

  // reset values
  localparam logic [CNT_W-1:0]  POS_RST  = 32'h0000_0000;
  localparam logic [CNT_W-1:0]  VEL_RST  = 32'h0000_0000;
  localparam logic [CNT_W-1:0]  IDX_RST  = 32'h0000_0000;
  localparam logic [FILT_W-1:0] FCNT_RST = 16'h0000;
  localparam logic [INT_W-1:0]  STAT_RST = 9'h000;
  localparam logic [CNT_W-1:0]  ONE      = 32'h0000_0001;
endpackage

/* verilog/glitch_filter.sv */
`timescale 1ns/1ps
// holds back a new level until it has stood for the programmed cycles
module glitch_filter (
  input  wire logic                         i_clk,
  input  wire logic                         i_rst_n,
  input  wire logic                         i_ce,
  input  wire logic [qdec_pkg::FILT_W-1:0]  i_dly,
  filt_if.filt                              line
);
  logic                        out_ff;   // accepted level
  logic                        nxt_out;
  logic [qdec_pkg::FILT_W-1:0] cnt_ff;   // cycles the new level has stood
  logic [qdec_pkg::FILT_W-1:0] nxt_cnt;

  // count while the input differs; any bounce back restarts the count
  always_comb begin
    nxt_out = out_ff;
    nxt_cnt = qdec_pkg::FCNT_RST;
    if (line.raw_lvl != out_ff) begin
      if (cnt_ff >= i_dly) begin
        nxt_out = line.raw_lvl; // [RULE15]
      end else begin
        nxt_cnt = cnt_ff + 16'h0001; // [RULE12]
      end
    end
  end

  // registers, frozen while clock enable is low
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      out_ff <= 1'b0;
      cnt_ff <= qdec_pkg::FCNT_RST;
    end else if (i_ce) begin
      out_ff <= nxt_out;
      cnt_ff <= nxt_cnt;
    end
  end

  assign line.clean_lvl = out_ff;
endmodule

/* verilog/match_detect.sv */
`timescale 1ns/1ps
// equality compare; pulses once when the value first reaches the target
module match_detect (
  input  wire logic                        i_clk,
  input  wire logic                        i_rst_n,
  input  wire logic                        i_ce,
  input  wire logic [qdec_pkg::CNT_W-1:0]  i_val,
  input  wire logic [qdec_pkg::CNT_W-1:0]  i_ref,
  output logic                             o_hit
);
  logic eq_ff;  // value equalled target last cycle
  logic nxt_eq;

  // level compare, edge taken so a parked counter does not re-fire
  always_comb begin
    nxt_eq = (i_val == i_ref);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      eq_ff <= 1'b0;
    end else if (i_ce) begin
      eq_ff <= nxt_eq;
    end
  end

  assign o_hit = nxt_eq & ~eq_ff;
endmodule

/* verilog/quadrature_decoder.sv */
`timescale 1ns/1ps
// encoder decoder: position, revolutions, velocity and event flags
module quadrature_decoder (
  input  wire logic                           I_CORE_CLK,
  input  wire logic                           I_RST_N,
  input  wire logic                           I_CE,
  input  wire logic                           I_PHA,
  input  wire logic                           I_PHB,
  input  wire logic                           I_IDX,
  input  wire logic [qdec_pkg::FILT_W-1:0]    I_FILT_DLY,
  input  wire logic                           I_MODE_4X,
  input  wire logic                           I_CLKDIR_MODE,
  input  wire logic                           I_DIR_INV,
  input  wire logic                           I_IDX_CLR_EN,
  input  wire logic                           I_POS_CLR,
  input  wire logic [qdec_pkg::CNT_W-1:0]     I_VEL_PERIOD,
  input  wire logic [qdec_pkg::CNT_W-1:0]     I_VEL_CMP,
  input  wire logic [qdec_pkg::CNT_W-1:0]     I_POS_CMP0,
  input  wire logic [qdec_pkg::CNT_W-1:0]     I_POS_CMP1,
  input  wire logic [qdec_pkg::CNT_W-1:0]     I_POS_CMP2,
  input  wire logic [qdec_pkg::CNT_W-1:0]     I_IDX_CMP,
  input  wire logic [qdec_pkg::INT_W-1:0]     I_INT_EN,
  input  wire logic [qdec_pkg::INT_W-1:0]     I_INT_CLR,
  output logic      [qdec_pkg::CNT_W-1:0]     O_POS,
  output logic      [qdec_pkg::CNT_W-1:0]     O_VEL,
  output logic      [qdec_pkg::CNT_W-1:0]     O_IDX_CNT,
  output logic                                O_DIR,
  output logic      [qdec_pkg::INT_W-1:0]     O_INT_STAT,
  output logic                                O_INT
);
  // filtered copies of the three encoder lines
  filt_if fa ();
  filt_if fb ();
  filt_if fi ();

  assign fa.raw_lvl = I_PHA;
  assign fb.raw_lvl = I_PHB;
  assign fi.raw_lvl = I_IDX;

  // one filter per line, all sharing the programmed delay
  glitch_filter u_filt_a (
    .i_clk   (I_CORE_CLK),
    .i_rst_n (I_RST_N),
    .i_ce    (I_CE),
    .i_dly   (I_FILT_DLY),
    .line    (fa.filt)
  );
  glitch_filter u_filt_b (
    .i_clk   (I_CORE_CLK),
    .i_rst_n (I_RST_N),
    .i_ce    (I_CE),
    .i_dly   (I_FILT_DLY),
    .line    (fb.filt)
  );
  glitch_filter u_filt_i (
    .i_clk   (I_CORE_CLK),
    .i_rst_n (I_RST_N),
    .i_ce    (I_CE),
    .i_dly   (I_FILT_DLY),
    .line    (fi.filt)
  );

  // previous filtered levels for edge detection
  logic a_ff;
  logic b_ff;
  logic i_ff;
  logic nxt_a;
  logic nxt_b;
  logic nxt_i;

  // counting state
  logic [qdec_pkg::CNT_W-1:0] pos_ff;      // signed position
  logic [qdec_pkg::CNT_W-1:0] nxt_pos;
  logic [qdec_pkg::CNT_W-1:0] idx_cnt_ff;  // revolution count
  logic [qdec_pkg::CNT_W-1:0] nxt_idx_cnt;
  logic                       dir_ff;      // 1 = counting up
  logic                       nxt_dir;

  // velocity measurement state
  logic [qdec_pkg::CNT_W-1:0] tim_ff;      // period down-counter
  logic [qdec_pkg::CNT_W-1:0] nxt_tim;
  logic [qdec_pkg::CNT_W-1:0] acc_ff;      // pulses in the running period
  logic [qdec_pkg::CNT_W-1:0] nxt_acc;
  logic [qdec_pkg::CNT_W-1:0] vel_ff;      // last captured velocity
  logic [qdec_pkg::CNT_W-1:0] nxt_vel;

  // event state
  logic [qdec_pkg::INT_W-1:0] stat_ff;     // sticky flags
  logic [qdec_pkg::INT_W-1:0] nxt_stat;
  logic                       int_ff;      // gated interrupt line
  logic                       nxt_int;

  // decode temporaries
  logic                       a_edge;      // phase A changed
  logic                       b_edge;      // phase B changed
  logic                       step;        // one count this cycle
  logic                       up_raw;      // direction before inversion
  logic                       up;          // direction actually used
  logic                       idx_rise;    // index pulse detected
  logic                       tim_end;     // velocity period over
  logic [qdec_pkg::INT_W-1:0] ev;          // events raised this cycle

  // compare hits
  logic hit_p0;
  logic hit_p1;
  logic hit_p2;
  logic hit_rev;

  // edge and direction decode
  always_comb begin
    a_edge   = fa.clean_lvl ^ a_ff;
    b_edge   = fb.clean_lvl ^ b_ff;
    idx_rise = fi.clean_lvl & ~i_ff;
    step     = 1'b0;
    up_raw   = dir_ff ^ I_DIR_INV;
    if (I_CLKDIR_MODE) begin
      // phase A is a count clock, phase B the direction level
      step   = fa.clean_lvl & ~a_ff; // [RULE13]
      up_raw = fb.clean_lvl; // [RULE13]
    end else if (I_MODE_4X) begin
      // both lines counted; a double change is illegal and dropped
      step = a_edge ^ b_edge; // [RULE4] [RULE14]
      if (step) begin
        up_raw = fa.clean_lvl ^ b_ff; // [RULE1]
      end
    end else begin
      // only phase A edges give counts, half the resolution
      step = a_edge & ~b_edge; // [RULE4] [RULE14]
      if (step) begin
        // a rise with B low, or a fall with B high, is phase A leading
        up_raw = fa.clean_lvl ^ fb.clean_lvl; // [RULE1]
      end
    end
    up = up_raw ^ I_DIR_INV;
  end

  // next-state for lines, position, revolutions, direction
  always_comb begin
    nxt_a       = fa.clean_lvl;
    nxt_b       = fb.clean_lvl;
    nxt_i       = fi.clean_lvl;
    nxt_dir     = step ? up : dir_ff;
    nxt_pos     = pos_ff;
    nxt_idx_cnt = idx_cnt_ff;
    if (step) begin
      nxt_pos = up ? pos_ff + qdec_pkg::ONE : pos_ff - qdec_pkg::ONE; // [RULE3] [RULE7]
    end
    // index clear wins over a count in the same cycle
    if (I_POS_CLR || (idx_rise && I_IDX_CLR_EN)) begin
      nxt_pos = qdec_pkg::POS_RST; // [RULE2]
    end
    if (idx_rise) begin
      nxt_idx_cnt = idx_cnt_ff + qdec_pkg::ONE; // [RULE9]
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      a_ff       <= 1'b0;
      b_ff       <= 1'b0;
      i_ff       <= 1'b0;
      dir_ff     <= 1'b1;
      pos_ff     <= qdec_pkg::POS_RST;
      idx_cnt_ff <= qdec_pkg::IDX_RST;
    end else if (I_CE) begin
      a_ff       <= nxt_a;
      b_ff       <= nxt_b;
      i_ff       <= nxt_i;
      dir_ff     <= nxt_dir;
      pos_ff     <= nxt_pos;
      idx_cnt_ff <= nxt_idx_cnt;
    end
  end

  // velocity: count steps until the period timer runs out, then capture
  always_comb begin
    tim_end = (tim_ff == qdec_pkg::VEL_RST);
    nxt_tim = tim_ff - qdec_pkg::ONE;
    nxt_acc = step ? acc_ff + qdec_pkg::ONE : acc_ff; // [RULE5]
    nxt_vel = vel_ff;
    if (tim_end) begin
      // period of zero still gives one cycle per window
      nxt_tim = I_VEL_PERIOD;
      nxt_vel = acc_ff; // [RULE5] [RULE7]
      nxt_acc = step ? qdec_pkg::ONE : qdec_pkg::VEL_RST;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      tim_ff <= qdec_pkg::VEL_RST;
      acc_ff <= qdec_pkg::VEL_RST;
      vel_ff <= qdec_pkg::VEL_RST;
    end else if (I_CE) begin
      tim_ff <= nxt_tim;
      acc_ff <= nxt_acc;
      vel_ff <= nxt_vel;
    end
  end

  // compares look at the next position so the hit lines up with it
  match_detect u_cmp0 (
    .i_clk   (I_CORE_CLK),
    .i_rst_n (I_RST_N),
    .i_ce    (I_CE),
    .i_val   (nxt_pos),
    .i_ref   (I_POS_CMP0),
    .o_hit   (hit_p0)
  );
  match_detect u_cmp1 (
    .i_clk   (I_CORE_CLK),
    .i_rst_n (I_RST_N),
    .i_ce    (I_CE),
    .i_val   (nxt_pos),
    .i_ref   (I_POS_CMP1),
    .o_hit   (hit_p1)
  );
  match_detect u_cmp2 (
    .i_clk   (I_CORE_CLK),
    .i_rst_n (I_RST_N),
    .i_ce    (I_CE),
    .i_val   (nxt_pos),
    .i_ref   (I_POS_CMP2),
    .o_hit   (hit_p2)
  );
  match_detect u_cmp_rev (
    .i_clk   (I_CORE_CLK),
    .i_rst_n (I_RST_N),
    .i_ce    (I_CE),
    .i_val   (nxt_idx_cnt),
    .i_ref   (I_IDX_CMP),
    .o_hit   (hit_rev)
  );

  // event collection; set beats a clear arriving in the same cycle
  always_comb begin
    ev                          = qdec_pkg::STAT_RST;
    ev[qdec_pkg::INT_IDX]       = idx_rise;
    ev[qdec_pkg::INT_TIM]       = tim_end;
    ev[qdec_pkg::INT_VELLT]     = tim_end && (acc_ff < I_VEL_CMP); // [RULE6]
    ev[qdec_pkg::INT_DIR]       = nxt_dir ^ dir_ff;
    ev[qdec_pkg::INT_POS0]      = hit_p0; // [RULE8]
    ev[qdec_pkg::INT_POS1]      = hit_p1; // [RULE8]
    ev[qdec_pkg::INT_POS2]      = hit_p2; // [RULE8]
    ev[qdec_pkg::INT_REV]       = hit_rev; // [RULE10]
    // whole turns reached and partial turn reached together
    ev[qdec_pkg::INT_COMB]      = hit_p0 && (nxt_idx_cnt == I_IDX_CMP); // [RULE11]
    nxt_stat = (stat_ff & ~I_INT_CLR) | ev; // [RULE16]
    nxt_int  = |(nxt_stat & I_INT_EN); // [RULE16]
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      stat_ff <= qdec_pkg::STAT_RST;
      int_ff  <= 1'b0;
    end else if (I_CE) begin
      stat_ff <= nxt_stat;
      int_ff  <= nxt_int;
    end
  end

  // every output straight from a register
  assign O_POS      = pos_ff;
  assign O_VEL      = vel_ff;
  assign O_IDX_CNT  = idx_cnt_ff;
  assign O_DIR      = dir_ff;
  assign O_INT_STAT = stat_ff;
  assign O_INT      = int_ff;
endmodule
